// [csa_core.sv]
// Status flags, stack pointer and effective-address logic of the CPU core.
// Assumes the sequencer drives one stack operation at a time and waits on stk_busy.
`timescale 1ns/1ps
`default_nettype none
module csa_core
    import csa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [15:0] mem_addr,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic mem_hit,
    output logic [7:0] mem_rdata,
    input wire logic [7:0] accumulator,
    input wire csa_alu_s alu_evt,
    input wire logic ninth_ld,
    input wire logic ninth_in,
    output logic ram_ninth_bit_flag,
    output logic [7:0] program_status_flags,
    output logic [15:0] stack_pointer,
    input wire csa_stk_e stk_op,
    input wire logic [8:0] stk_wdata,
    input wire logic [16:0] ret_pc_in,
    input wire logic code_bank_bit,
    output logic stk_busy,
    output logic [15:0] ram_addr,
    output logic ram_we,
    output logic ram_re,
    output logic [8:0] ram_wdata,
    input wire logic [8:0] ram_rdata,
    output logic pop_valid,
    output logic [8:0] pop_data,
    output logic ret_valid,
    output logic [16:0] ret_pc,
    output logic ret_bank,
    input wire logic [5:0] ptr_index,
    output logic [15:0] ptr_byte_addr,
    input wire csa_ea_req_s ea_req,
    output csa_ea_res_s ea_res
);

    typedef enum logic [1:0] {
        CSA_ST_IDLE,
        CSA_ST_CALL2,
        CSA_ST_RET2
    } csa_st_e;

    logic rst_meta_r;
    logic rst_n_r;
    logic [7:1] flags_r;
    logic [7:1] flags_nxt;
    logic [15:0] sp_r;
    logic [15:0] sp_nxt;
    logic [7:0] rdata_r;
    csa_st_e st_r;
    csa_st_e st_nxt;
    logic pop_valid_r;
    logic [8:0] pop_data_r;
    logic ret_valid_r;
    logic [8:0] ret_high_r;
    logic [16:0] ret_pc_r;
    logic ret_bank_r;
    logic [7:0] call_high_r;
    logic call_high_bit_r;
    csa_ea_res_s ea_r;
    csa_ea_res_s ea_nxt;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Register decode
    wire sel_status = (mem_addr == CSA_STATUS_ADDR);
    wire sel_sp_low = (mem_addr == CSA_SP_LOW_ADDR);
    wire sel_sp_high = (mem_addr == CSA_SP_HIGH_ADDR);
    wire wr_status = mem_wr && sel_status;
    wire parity = ^accumulator;
    wire [7:0] status_view = {flags_r, parity};
    assign mem_hit = sel_status || sel_sp_low || sel_sp_high;

    // Flag arithmetic
    wire [15:0] op_b_eff = (alu_evt.op == CSA_OP_ADD) ? alu_evt.b : ~alu_evt.b;
    wire cin_eff = (alu_evt.op == CSA_OP_ADD) ? alu_evt.cin : ~alu_evt.cin;
    wire [16:0] sum16 = {1'b0, alu_evt.a} + {1'b0, op_b_eff} + {16'h0000, cin_eff};
    wire [8:0] sum8 = {1'b0, alu_evt.a[7:0]} + {1'b0, op_b_eff[7:0]} + {8'h00, cin_eff};
    wire [4:0] nib_lo = {1'b0, alu_evt.a[3:0]} + {1'b0, op_b_eff[3:0]} + {4'h0, cin_eff};
    wire carry_into_hi = sum16[8] ^ alu_evt.a[8] ^ op_b_eff[8];
    wire [4:0] nib_hi = {1'b0, alu_evt.a[11:8]} + {1'b0, op_b_eff[11:8]} + {4'h0, carry_into_hi};
    wire raw_carry = alu_evt.wide ? sum16[16] : sum8[8];
    wire raw_half = alu_evt.wide ? nib_hi[4] : nib_lo[4];
    wire sign_a = alu_evt.wide ? alu_evt.a[15] : alu_evt.a[7];
    wire sign_b = alu_evt.wide ? op_b_eff[15] : op_b_eff[7];
    wire sign_r = alu_evt.wide ? sum16[15] : sum8[7];
    wire is_addsub = (alu_evt.op == CSA_OP_ADD) || (alu_evt.op == CSA_OP_SUB);
    // Subtraction is done as a + ~b + ~borrow, so the borrow is the inverted carry
    wire is_sub = (alu_evt.op != CSA_OP_ADD);
    wire carry_res = (alu_evt.op == CSA_OP_ROT) ? alu_evt.rot_out : (raw_carry ^ is_sub);
    wire half_res = raw_half ^ is_sub;
    wire signed_ovf = (sign_a == sign_b) && (sign_r != sign_a);
    wire mul_ovf = (alu_evt.op == CSA_OP_MUL16) ? (alu_evt.prod_hi[7:0] != 8'h00) : (alu_evt.prod_hi != 16'h0000);
    wire upd_carry = alu_evt.valid && (is_addsub || alu_evt.op == CSA_OP_CMP || alu_evt.op == CSA_OP_ROT);
    wire upd_half = alu_evt.valid && is_addsub;
    wire upd_over = alu_evt.valid && (alu_evt.op != CSA_OP_CMP) && (alu_evt.op != CSA_OP_ROT);
    wire over_res = is_addsub ? signed_ovf : ((alu_evt.op == CSA_OP_DIV) ? alu_evt.div_zero : mul_ovf);

    // Status next value: software write first, hardware updates override
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_status)
        begin
            flags_nxt = mem_wdata[7:1];
        end
        if (upd_carry)
        begin
            flags_nxt[CSA_CARRY_BIT] = carry_res;
        end
        if (upd_half)
        begin
            flags_nxt[CSA_HALF_BIT] = half_res;
        end
        if (upd_over)
        begin
            flags_nxt[CSA_OVER_BIT] = over_res;
        end
        if (ninth_ld)
        begin
            flags_nxt[CSA_NINTH_BIT] = ninth_in;
        end
        if (st_r == CSA_ST_IDLE && stk_op == CSA_STK_POP)
        begin
            flags_nxt[CSA_NINTH_BIT] = ram_rdata[8];
        end
    end

    // Stack sequencing
    wire [15:0] sp_inc = sp_r + 16'h0001;
    wire [15:0] sp_dec = sp_r - 16'h0001;
    wire idle = (st_r == CSA_ST_IDLE);
    wire do_push = idle && (stk_op == CSA_STK_PUSH);
    wire do_pop = idle && (stk_op == CSA_STK_POP);
    wire do_call = idle && (stk_op == CSA_STK_CALL);
    wire do_ret = idle && (stk_op == CSA_STK_RET);
    wire call2 = (st_r == CSA_ST_CALL2);
    wire ret2 = (st_r == CSA_ST_RET2);

    // Pointer always moves before a write and after a read
    assign ram_addr = (do_push || do_call || call2) ? sp_inc : sp_r;
    assign ram_we = do_push || do_call || call2;
    assign ram_re = do_pop || do_ret || ret2;
    assign ram_wdata = do_call ? {code_bank_bit, ret_pc_in[7:0]} :
                       (call2 ? {call_high_bit_r, call_high_r} : stk_wdata);
    assign stk_busy = !idle;

    always_comb
    begin
        st_nxt = st_r;
        sp_nxt = sp_r;
        if (mem_wr && sel_sp_low)
        begin
            sp_nxt[7:0] = mem_wdata;
        end
        if (mem_wr && sel_sp_high)
        begin
            sp_nxt[15:8] = mem_wdata;
        end
        unique case (st_r)
            CSA_ST_IDLE:
            begin
                if (do_push || do_call)
                begin
                    sp_nxt = sp_inc;
                end
                if (do_pop || do_ret)
                begin
                    sp_nxt = sp_dec;
                end
                if (do_call)
                begin
                    st_nxt = CSA_ST_CALL2;
                end
                if (do_ret)
                begin
                    st_nxt = CSA_ST_RET2;
                end
            end
            CSA_ST_CALL2:
            begin
                sp_nxt = sp_inc;
                st_nxt = CSA_ST_IDLE;
            end
            CSA_ST_RET2:
            begin
                sp_nxt = sp_dec;
                st_nxt = CSA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            flags_r <= CSA_STATUS_RESET[7:1];
            sp_r <= CSA_SP_RESET;
            st_r <= CSA_ST_IDLE;
            rdata_r <= 8'h00;
        end
        else
        begin
            flags_r <= flags_nxt;
            sp_r <= sp_nxt;
            st_r <= st_nxt;
            rdata_r <= sel_status ? status_view : (sel_sp_low ? sp_r[7:0] : (sel_sp_high ? sp_r[15:8] : 8'h00));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pop_valid_r <= 1'b0;
            pop_data_r <= 9'h000;
            ret_valid_r <= 1'b0;
            ret_high_r <= 9'h000;
            ret_pc_r <= 17'h00000;
            ret_bank_r <= 1'b0;
            call_high_r <= 8'h00;
            call_high_bit_r <= 1'b0;
        end
        else
        begin
            pop_valid_r <= do_pop;
            if (do_pop)
            begin
                pop_data_r <= ram_rdata;
            end
            if (do_call)
            begin
                call_high_r <= ret_pc_in[15:8];
                call_high_bit_r <= ret_pc_in[16];
            end
            if (do_ret)
            begin
                ret_high_r <= ram_rdata;
            end
            ret_valid_r <= ret2;
            if (ret2)
            begin
                ret_pc_r <= {ret_high_r, ram_rdata[7:0]};
                ret_bank_r <= ram_rdata[8];
            end
        end
    end

    // Address generation
    wire [15:0] c_ext = {{8{ea_req.c_reg[7]}}, ea_req.c_reg};
    wire [15:0] off_ext = {{9{ea_req.off[6]}}, ea_req.off};
    wire [15:0] idx_sum = ea_req.ptr + ((ea_req.mode == CSA_MODE_OFF) ? off_ext : c_ext);
    wire base_ram = (ea_req.ptr <= CSA_RAM_TOP);
    wire base_sfr = (ea_req.ptr[15:8] == CSA_SFR_PAGE);
    wire indexed = (ea_req.mode == CSA_MODE_IND_C) || (ea_req.mode == CSA_MODE_OFF);
    // A negative index below 0000H wraps high and must also leave the RAM area
    wire ram_escape = base_ram && ((idx_sum > CSA_RAM_TOP) || (idx_sum > ea_req.ptr && idx_sum[15] != ea_req.ptr[15]));
    wire [15:0] idx_addr = base_sfr ? {CSA_SFR_PAGE, idx_sum[7:0]} : idx_sum;
    assign ptr_byte_addr = {9'h000, ptr_index, 1'b0};

    always_comb
    begin
        ea_nxt = '0;
        ea_nxt.valid = ea_req.valid;
        ea_nxt.ext_addr = {ea_req.b_reg, ea_req.ptr};
        ea_nxt.code_addr = {flags_r[CSA_BANK_BIT], flags_r[CSA_NINTH_BIT], ea_req.ptr};
        unique case (ea_req.mode)
            CSA_MODE_IMM:
            begin
                ea_nxt.imm = ea_req.imm;
            end
            CSA_MODE_IND:
            begin
                ea_nxt.addr = ea_req.ptr;
            end
            CSA_MODE_IND_C, CSA_MODE_OFF:
            begin
                ea_nxt.addr = idx_addr;
                ea_nxt.force_ff = ram_escape;
            end
            CSA_MODE_DIR:
            begin
                ea_nxt.addr = ea_req.direct;
            end
            CSA_MODE_TBL, CSA_MODE_EXT:
            begin
                ea_nxt.addr = ea_req.ptr;
            end
            default:
            begin
                ea_nxt.addr = ea_req.ptr;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ea_r <= '0;
        end
        else
        begin
            ea_r <= ea_nxt;
        end
    end

    assign mem_rdata = rdata_r;
    assign program_status_flags = status_view;
    assign ram_ninth_bit_flag = flags_r[CSA_NINTH_BIT];
    assign stack_pointer = sp_r;
    assign pop_valid = pop_valid_r;
    assign pop_data = pop_data_r;
    assign ret_valid = ret_valid_r;
    assign ret_pc = ret_pc_r;
    assign ret_bank = ret_bank_r;
    assign ea_res = ea_r;

    // Checks
    sequence call_first_s;
        st_r == CSA_ST_IDLE && stk_op == CSA_STK_CALL;
    endsequence
    sequence call_second_s;
        st_r == CSA_ST_CALL2 && ram_we && ram_addr == $past(sp_r) + 16'h0002;
    endsequence

    status_reset_a: assert property (@(posedge sys_clk) $rose(rst_n_r) |-> flags_r == 7'h00)
        else $error("status not cleared by reset");
    parity_track_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        program_status_flags[0] == ^accumulator)
        else $error("parity does not match accumulator");
    push_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        do_push && !mem_wr |-> ram_addr == sp_r + 16'h0001 ##1 sp_r == $past(ram_addr))
        else $error("push did not increment before write");
    pop_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        do_pop && !mem_wr |-> ram_addr == sp_r ##1 sp_r == $past(ram_addr) - 16'h0001 && pop_valid)
        else $error("pop did not read before decrement");
    call_seq_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        call_first_s |-> ram_wdata[8] == code_bank_bit ##1 call_second_s)
        else $error("call push order wrong");
    ret_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        do_ret |-> ##2 ret_valid ##0 ret_pc[16:8] == $past(ram_rdata, 2))
        else $error("return pop order wrong");
    carry_add_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        alu_evt.valid && alu_evt.op == CSA_OP_ADD && !alu_evt.wide && !ninth_ld
        |=> flags_r[7] ==
        ($past({1'b0, alu_evt.a[7:0]} + {1'b0, alu_evt.b[7:0]} + {8'h00, alu_evt.cin}) > 9'h0FF))
        else $error("carry after add wrong");
    div_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        alu_evt.valid && alu_evt.op == CSA_OP_DIV |=> flags_r[2] == $past(alu_evt.div_zero))
        else $error("overflow on divide wrong");
    ram_escape_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ea_req.valid && indexed && base_ram && idx_sum > CSA_RAM_TOP |=> ea_res.force_ff)
        else $error("escape from RAM area not flagged");
    sfr_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ea_req.valid && indexed && base_sfr |=> ea_res.addr[15:8] == CSA_SFR_PAGE && !ea_res.force_ff)
        else $error("SFR index left its page");

endmodule
`default_nettype wire

// [csa_pkg.sv]
// Package for the status, stack and addressing slice of the CPU core.
// Assumes a 16-bit data-memory map with SFR page at FE00H.
package csa_pkg;

    localparam logic [15:0] CSA_STATUS_ADDR = 16'hFE06;
    localparam logic [15:0] CSA_SP_LOW_ADDR = 16'hFE0A;
    localparam logic [15:0] CSA_SP_HIGH_ADDR = 16'hFE0B;
    localparam logic [7:0] CSA_STATUS_RESET = 8'h00;
    localparam logic [15:0] CSA_SP_RESET = 16'h0000;

    localparam int CSA_CARRY_BIT = 7;
    localparam int CSA_HALF_BIT = 6;
    localparam int CSA_USER5_BIT = 5;
    localparam int CSA_USER4_BIT = 4;
    localparam int CSA_BANK_BIT = 3;
    localparam int CSA_OVER_BIT = 2;
    localparam int CSA_NINTH_BIT = 1;
    localparam int CSA_PARITY_BIT = 0;

    localparam logic [15:0] CSA_RAM_TOP = 16'hFDFF;
    localparam logic [7:0] CSA_SFR_PAGE = 8'hFE;
    localparam logic [7:0] CSA_OUT_OF_AREA = 8'hFF;

    typedef enum logic [2:0] {
        CSA_OP_ADD,
        CSA_OP_SUB,
        CSA_OP_CMP,
        CSA_OP_ROT,
        CSA_OP_MUL16,
        CSA_OP_MUL24,
        CSA_OP_DIV
    } csa_op_e;

    typedef enum logic [2:0] {
        CSA_MODE_IMM,
        CSA_MODE_IND,
        CSA_MODE_IND_C,
        CSA_MODE_OFF,
        CSA_MODE_DIR,
        CSA_MODE_TBL,
        CSA_MODE_EXT
    } csa_mode_e;

    typedef enum logic [2:0] {
        CSA_STK_NONE,
        CSA_STK_PUSH,
        CSA_STK_POP,
        CSA_STK_CALL,
        CSA_STK_RET
    } csa_stk_e;

    typedef struct packed {
        logic valid;
        csa_op_e op;
        logic wide;
        logic [15:0] a;
        logic [15:0] b;
        logic cin;
        logic rot_out;
        logic [15:0] prod_hi;
        logic div_zero;
    } csa_alu_s;

    typedef struct packed {
        logic valid;
        csa_mode_e mode;
        logic [15:0] ptr;
        logic [7:0] c_reg;
        logic [6:0] off;
        logic [15:0] direct;
        logic [15:0] imm;
        logic [7:0] b_reg;
    } csa_ea_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic force_ff;
        logic [15:0] imm;
        logic [17:0] code_addr;
        logic [23:0] ext_addr;
    } csa_ea_res_s;

endpackage

// [csa_ram_model.sv]
// Behavioural model of the 9-bit internal RAM on the core's RAM port.
// Assumes asynchronous reads and writes taken on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module csa_ram_model
(
    input wire logic sys_clk,
    input wire logic [15:0] ram_addr,
    input wire logic ram_we,
    input wire logic ram_re,
    input wire logic [8:0] ram_wdata,
    output logic [8:0] ram_rdata
);
    logic [8:0] mem [0:511];
    logic [8:0] last_r = 9'h000;
    // Nine bits per location, 512 locations selected by ram_addr[8:0] only
    always @(posedge sys_clk)
    begin
        if (ram_we)
        begin
            mem[ram_addr[8:0]] <= ram_wdata;
        end
        if (ram_re)
        begin
            last_r <= mem[ram_addr[8:0]];
        end
    end
    // Idle port shows inverted last value
    assign ram_rdata = ram_re ? mem[ram_addr[8:0]] : ~last_r;
endmodule
`default_nettype wire

// [tb_cpu_status_stack_addressing.sv]
// Testbench for the status, stack and addressing slice.
// Assumes the RAM model above on the RAM port; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_status_stack_addressing
    import csa_pkg::*;
;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] mem_addr = 16'h0000;
    logic mem_wr = 1'b0;
    logic [7:0] mem_wdata = 8'h00;
    logic [7:0] accumulator = 8'h01;
    csa_alu_s alu_evt = '0;
    logic ninth_ld = 1'b0;
    logic ninth_in = 1'b0;
    csa_stk_e stk_op = CSA_STK_NONE;
    logic [8:0] stk_wdata = 9'h000;
    logic [16:0] ret_pc_in = 17'h00000;
    logic code_bank_bit = 1'b0;
    logic [5:0] ptr_index = 6'h00;
    csa_ea_req_s ea_req = '0;
    logic mem_hit, ram_ninth_bit_flag, stk_busy, ram_we, ram_re, pop_valid, ret_valid, ret_bank;
    logic [7:0] mem_rdata, program_status_flags;
    logic [15:0] stack_pointer, ram_addr, ptr_byte_addr;
    logic [8:0] ram_wdata, ram_rdata, pop_data;
    logic [16:0] ret_pc;
    csa_ea_res_s ea_res, res_q;
    logic [17:0] got_q;
    int err_total = 0;
    int n_checks = 0;

    always #25 sys_clk = ~sys_clk;

    csa_core csa_core_i (.sys_clk, .arst_n, .mem_addr, .mem_wr, .mem_wdata, .mem_hit, .mem_rdata,
        .accumulator, .alu_evt, .ninth_ld, .ninth_in, .ram_ninth_bit_flag, .program_status_flags,
        .stack_pointer, .stk_op, .stk_wdata, .ret_pc_in, .code_bank_bit, .stk_busy, .ram_addr,
        .ram_we, .ram_re, .ram_wdata, .ram_rdata, .pop_valid, .pop_data, .ret_valid, .ret_pc,
        .ret_bank, .ptr_index, .ptr_byte_addr, .ea_req, .ea_res);
    csa_ram_model csa_ram_model_i (.sys_clk, .ram_addr, .ram_we, .ram_re, .ram_wdata, .ram_rdata);

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'b1;
        @(negedge sys_clk);
        mem_wr = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic bus_rd(input logic [15:0] a, input logic [7:0] e);
        mem_addr = a;
        repeat (2) @(negedge sys_clk);
        chk(mem_rdata, e);
    endtask

    task automatic alu(input csa_op_e op, input logic w, input logic [15:0] a, input logic [15:0] b,
        input logic [2:0] e);
        logic [2:0] m;
        m = (op == CSA_OP_ADD || op == CSA_OP_SUB) ? 3'h7 : (op == CSA_OP_CMP || op == CSA_OP_ROT) ? 3'h4 : 3'h1;
        alu_evt = '{1'b1, op, w, a, b, 1'b0, a[0], a, a[0]};
        @(negedge sys_clk);
        alu_evt.valid = 1'b0;
        @(negedge sys_clk);
        chk({program_status_flags[7:6], program_status_flags[2]} & m, e);
    endtask

    task automatic stk(input csa_stk_e op);
        int i;
        stk_op = op;
        got_q = 'x;
        for (i = 0; i < 6; i++)
        begin
            @(negedge sys_clk);
            stk_op = CSA_STK_NONE;
            if (i == 0)
            begin
                chk(stk_busy, (op == CSA_STK_CALL || op == CSA_STK_RET));
            end
            if (pop_valid === 1'b1)
            begin
                got_q = {9'h000, pop_data};
            end
            if (ret_valid === 1'b1)
            begin
                got_q = {ret_bank, ret_pc};
            end
        end
    endtask

    task automatic ea(input csa_mode_e m, input logic [15:0] p, input logic [7:0] c, input logic [6:0] o,
        input logic [15:0] v);
        ea_req = '{1'b1, m, p, c, o, v, v, 8'h12};
        @(negedge sys_clk);
        ea_req.valid = 1'b0;
        res_q = ea_res;
        chk(res_q.valid, 1'b1);
    endtask

    task automatic t_reset();
        chk(program_status_flags, 8'h01);
        chk(stack_pointer, CSA_SP_RESET);
        bus_rd(CSA_SP_LOW_ADDR, 8'h00);
        bus_rd(CSA_SP_HIGH_ADDR, 8'h00);
        bus_rd(16'hFE00, 8'h00);
        chk(mem_hit, 1'b0);
        bus_rd(CSA_STATUS_ADDR, 8'h01);
        chk(mem_hit, 1'b1);
        ptr_index = 6'h3F;
        #1 chk(ptr_byte_addr, 16'h007E);
    endtask

    task automatic t_flags_sw();
        accumulator = 8'h07;
        bus_wr(CSA_STATUS_ADDR, 8'hFF);
        chk(program_status_flags, 8'hFF);
        bus_rd(CSA_STATUS_ADDR, 8'hFF);
        accumulator = 8'h03;
        @(negedge sys_clk);
        chk(program_status_flags, 8'hFE);
        bus_wr(CSA_STATUS_ADDR, 8'h08);
        chk(program_status_flags, 8'h08);
        ea(CSA_MODE_TBL, 16'h5678, 8'h00, 7'h00, 16'h0000);
        chk(res_q.code_addr, 18'h25678);
        bus_wr(CSA_STATUS_ADDR, 8'h02);
        ea(CSA_MODE_TBL, 16'h5678, 8'h00, 7'h00, 16'h0000);
        chk(res_q.code_addr, 18'h15678);
        ninth_ld = 1'b1;
        @(negedge sys_clk);
        ninth_ld = 1'b0;
        @(negedge sys_clk);
        chk({ram_ninth_bit_flag, program_status_flags}, 9'h000);
    endtask

    task automatic t_alu();
        alu(CSA_OP_ADD, 1'b0, 16'h0088, 16'h0088, 3'h7);
        alu(CSA_OP_ADD, 1'b0, 16'h0001, 16'h0001, 3'h0);
        alu(CSA_OP_ADD, 1'b0, 16'h007F, 16'h0001, 3'h3);
        alu(CSA_OP_SUB, 1'b0, 16'h0010, 16'h0001, 3'h2);
        alu(CSA_OP_SUB, 1'b0, 16'h0080, 16'h0001, 3'h3);
        alu(CSA_OP_SUB, 1'b0, 16'h0000, 16'h0001, 3'h6);
        alu(CSA_OP_ADD, 1'b1, 16'h0800, 16'h0800, 3'h2);
        alu(CSA_OP_ADD, 1'b1, 16'h8000, 16'h8000, 3'h5);
        alu(CSA_OP_CMP, 1'b0, 16'h0002, 16'h0003, 3'h4);
        alu(CSA_OP_CMP, 1'b0, 16'h0003, 16'h0002, 3'h0);
        alu(CSA_OP_ROT, 1'b0, 16'h0001, 16'h0000, 3'h4);
        alu(CSA_OP_ROT, 1'b0, 16'h0000, 16'h0000, 3'h0);
        alu(CSA_OP_MUL16, 1'b0, 16'h0001, 16'h0000, 3'h1);
        alu(CSA_OP_MUL16, 1'b0, 16'h0100, 16'h0000, 3'h0);
        alu(CSA_OP_MUL24, 1'b0, 16'h8000, 16'h0000, 3'h1);
        alu(CSA_OP_DIV, 1'b0, 16'h0000, 16'h0000, 3'h0);
        alu(CSA_OP_DIV, 1'b0, 16'h0001, 16'h0000, 3'h1);
    endtask

    task automatic t_stack();
        bus_wr(CSA_SP_LOW_ADDR, 8'h10);
        bus_wr(CSA_SP_HIGH_ADDR, 8'h01);
        chk(stack_pointer, 16'h0110);
        bus_rd(CSA_SP_HIGH_ADDR, 8'h01);
        stk_wdata = 9'h1A5;
        stk(CSA_STK_PUSH);
        chk(stack_pointer, 16'h0111);
        chk(csa_ram_model_i.mem[9'h111], 9'h1A5);
        ret_pc_in = 17'h1ABCD;
        code_bank_bit = 1'b1;
        stk(CSA_STK_CALL);
        chk(stack_pointer, 16'h0113);
        chk(csa_ram_model_i.mem[9'h112], 9'h1CD);
        chk(csa_ram_model_i.mem[9'h113], 9'h1AB);
        stk(CSA_STK_RET);
        chk(got_q, {1'b1, 17'h1ABCD});
        chk(stack_pointer, 16'h0111);
        stk(CSA_STK_POP);
        chk(got_q, 18'h001A5);
        chk(stack_pointer, 16'h0110);
        chk(program_status_flags[1], 1'b1);
    endtask

    task automatic t_ea();
        ea(CSA_MODE_IMM, 16'h0000, 8'h00, 7'h00, 16'h1234);
        chk(res_q.imm, 16'h1234);
        ea(CSA_MODE_IND, 16'h0123, 8'h00, 7'h00, 16'h0000);
        chk({res_q.force_ff, res_q.addr}, 17'h00123);
        ea(CSA_MODE_IND_C, 16'hFE02, 8'hFF, 7'h00, 16'h0000);
        chk({res_q.force_ff, res_q.addr}, 17'h0FE01);
        ea(CSA_MODE_IND_C, 16'h0100, 8'h80, 7'h00, 16'h0000);
        chk({res_q.force_ff, res_q.addr}, 17'h00080);
        ea(CSA_MODE_OFF, 16'hFE02, 8'h00, 7'h7E, 16'h0000);
        chk({res_q.force_ff, res_q.addr}, 17'h0FE00);
        ea(CSA_MODE_OFF, 16'h0123, 8'h00, 7'h3F, 16'h0000);
        chk({res_q.force_ff, res_q.addr}, 17'h00162);
        ea(CSA_MODE_IND_C, 16'hFDFF, 8'h01, 7'h00, 16'h0000);
        chk(res_q.force_ff, 1'b1);
        ea(CSA_MODE_OFF, 16'hFEFF, 8'h00, 7'h02, 16'h0000);
        chk({res_q.force_ff, res_q.addr}, 17'h0FE01);
        ea(CSA_MODE_DIR, 16'h0000, 8'h00, 7'h00, 16'h0123);
        chk(res_q.addr, 16'h0123);
        ea(CSA_MODE_EXT, 16'h3456, 8'h00, 7'h00, 16'h0000);
        chk(res_q.ext_addr, 24'h123456);
    endtask

    initial
    begin
        #3000000;
        err_total++;
        final_report();
    end

    initial
    begin
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_flags_sw();
        t_alu();
        t_stack();
        t_ea();
        final_report();
    end
endmodule
`default_nettype wire
